/* File: hdl/smf_ctrl.sv */
// mode and fault controller of a can system basis chip
// assumes analog comparator flags and host pins are asynchronous to mclk
//
// Operation
// - overtemperature enters fail-safe, transceiver off
// - thermal clear only on falling comparator
// - repeated overtemperature re-enters fail-safe
// - io undervoltage sleeps, regulator undervoltage resets
// - reset holds while regulator undervoltage persists
// - regulator overvoltage enters fail-safe
// - inactivity timer runs only in standby
// - transitions stop timer, never in normal
// - timeout drives rx low, then sleep
// - mode from sleep input, faults, wakes
// - regulators on in normal, standby, reset
// - inhibit active in normal, standby, reset
// - fail-safe ignores wakes until faults clear
// - normal mode enables driver and receiver
// - normal passes tx to bus, bus to rx
// - host holds sleep input low to sleep
// - sleep input low from normal gives standby
// - standby latches rx low on wake/fault
// - cold reset holds reset line low
`timescale 1ns/1ps
module smf_ctrl
   import smf_pkg::*;
#(
   parameter int unsigned INACTIVE_CNT  = INACTIVE_CYC,
   parameter int unsigned COLD_RST_CNT  = COLD_RST_CYC,
   parameter int unsigned SLEEP_CNT     = SLEEP_HOLD_CYC
) (
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic sleep_control_n,     // host mode pin
   input  wire logic tx_data_in,          // host transmit data
   input  wire logic bus_rx_in,           // received bus state
   input  wire logic ot_rise,             // junction above upper threshold
   input  wire logic ot_fall,             // junction below lower threshold
   input  wire logic uv_io,               // io_supply undervoltage
   input  wire logic uv_reg,              // any regulator undervoltage
   input  wire logic ov_reg,              // any regulator overvoltage
   input  wire logic wake_evt,            // remote or local wake
   input  wire logic reset_n_io_in,       // reset line level
   output logic      reset_n_io_out,      // drive value, always low
   output logic      reset_n_io_oe,       // high while pulling low
   output logic      bus_tx_en,           // bus driver enable
   output logic      bus_rx_en,           // bus receiver enable
   output logic      bus_tx_out,          // bus drive level
   output logic      rx_data_out,         // receive data / wake flag
   output logic      reg_en,              // regulator enables
   output logic      supply_inhibit_out,  // system supply enable
   output logic      overtemperature_fault,
   output logic [2:0] mode_out            // current mode code
);
   // elaboration checks on the timer parameters
   if (INACTIVE_CNT < 2 || COLD_RST_CNT < 2 || SLEEP_CNT < 2) begin : g_chk_small
      $error("smf_ctrl: timer counts too small");
   end
   if (INACTIVE_CNT >= (1 << TMR_W) || COLD_RST_CNT >= (1 << TMR_W) ||
       SLEEP_CNT >= (1 << TMR_W)) begin : g_chk_wide
      $error("smf_ctrl: timer counts too wide");
   end

   // =========================================================
   // input synchronisation
   localparam int unsigned NS = 10;
   localparam logic [NS-1:0] SYNC_IDLE = 10'h381; // pins at idle level
   logic [NS-1:0] s_w;
   smf_sync #(.W(NS), .RST_VAL(SYNC_IDLE)) u_sync (
      .mclk     (mclk),
      .rst_b    (rst_b),
      .async_in ({sleep_control_n, tx_data_in, bus_rx_in, ot_rise, ot_fall,
                  uv_io, uv_reg, ov_reg, wake_evt, reset_n_io_in}),
      .sync_out (s_w)
   );
   logic slp_n_s, txd_s, brx_s, otr_s, otf_s, uvio_s, uvreg_s, ovreg_s, wake_s;
   assign {slp_n_s, txd_s, brx_s, otr_s, otf_s, uvio_s, uvreg_s, ovreg_s, wake_s}
          = s_w[NS-1:1];

   // =========================================================
   // state
   smf_mode_e       mode_r;           // current mode
   smf_mode_e       mode_nxt;         // next mode
   logic            tsd_r;            // thermal fault pending
   logic [TMR_W-1:0] inact_r;         // inactivity timer
   logic [TMR_W-1:0] slp_r;           // sleep hold counter
   logic [TMR_W-1:0] rst_cnt_r;       // cold reset counter
   logic            timeout_w;        // inactivity expiry
   logic            slp_hold_w;       // sleep input held long enough
   logic            cold_done_w;      // cold reset hold finished
   logic            fault_w;          // any fault pending
   logic            rxd_latch_r;      // wake/fault indication latched
   logic            rxd_set_w;        // latch set condition this cycle

   assign timeout_w   = (mode_r == SMF_STANDBY) && (inact_r == TMR_W'(INACTIVE_CNT - 1));
   assign slp_hold_w  = (slp_r == TMR_W'(SLEEP_CNT - 1));
   assign cold_done_w = (rst_cnt_r == TMR_W'(COLD_RST_CNT - 1));
   assign fault_w     = tsd_r || otr_s || ovreg_s;
   // pending wake, fault, power-up or timeout
   assign rxd_set_w   = (mode_r != SMF_NORMAL) && (wake_s || fault_w || uvreg_s || timeout_w ||
                        mode_r == SMF_OFF || mode_r == SMF_RESET);

   // =========================================================
   // thermal fault flag
   // clear on falling comparator; set again each rise
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tsd_r <= 1'b0;
      end else if (otr_s) begin
         tsd_r <= 1'b1;                   // set wins over clear
      end else if (otf_s) begin
         tsd_r <= 1'b0;
      end
   end

   // =========================================================
   // next mode selection
   // mode from sleep input, faults and wakes
   always_comb begin
      mode_nxt = mode_r;
      case (mode_r)
         SMF_OFF: begin
            mode_nxt = SMF_RESET;             // power-up is a cold reset
         end
         SMF_NORMAL, SMF_STANDBY: begin
            if (!slp_n_s && slp_hold_w && !wake_s && !rxd_latch_r && !uvio_s) begin
               mode_nxt = SMF_SLEEP;
            end else if (timeout_w) begin
               mode_nxt = SMF_SLEEP;
            end else if (mode_r == SMF_NORMAL && !slp_n_s) begin
               mode_nxt = SMF_STANDBY;
            end else if (mode_r == SMF_STANDBY && slp_n_s) begin
               mode_nxt = SMF_NORMAL;
            end
         end
         SMF_RESET: begin
            if (!uvreg_s && cold_done_w) begin
               mode_nxt = slp_n_s ? SMF_NORMAL : SMF_STANDBY;
            end
         end
         SMF_SLEEP: begin
            if (wake_s && !uvio_s) begin
               mode_nxt = SMF_STANDBY;
            end
         end
         SMF_FAILSAFE: begin
            // wakes ignored while a fault pends
            if (!fault_w && wake_s) begin
               mode_nxt = SMF_RESET;
            end
         end
         default: mode_nxt = SMF_RESET;
      endcase
      // fault overrides, highest priority last
      if (mode_r != SMF_OFF) begin
         if (uvio_s && mode_r != SMF_FAILSAFE) begin
            mode_nxt = SMF_SLEEP;
         end
         if (uvreg_s && mode_r != SMF_SLEEP && mode_r != SMF_FAILSAFE) begin
            mode_nxt = SMF_RESET;
         end
         if (otr_s || ovreg_s) begin
            mode_nxt = SMF_FAILSAFE;
         end
      end
   end

   // =========================================================
   // mode register
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mode_r <= SMF_OFF;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // =========================================================
   // inactivity timer
   // runs only while staying in standby
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         inact_r <= '0;
      end else if (mode_r != SMF_STANDBY || mode_nxt != mode_r) begin
         inact_r <= '0;
      end else begin
         inact_r <= inact_r + TMR_W'(1);
      end
   end

   // =========================================================
   // sleep hold counter on the sleep input
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         slp_r <= '0;
      end else if (slp_n_s || !(mode_r == SMF_NORMAL || mode_r == SMF_STANDBY)) begin
         slp_r <= '0;
      end else if (!slp_hold_w) begin
         slp_r <= slp_r + TMR_W'(1);
      end
   end

   // =========================================================
   // cold reset counter
   // hold reset line low for the cold duration
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rst_cnt_r <= '0;
      end else if (mode_r != SMF_RESET || uvreg_s) begin
         rst_cnt_r <= '0;
      end else if (!cold_done_w) begin
         rst_cnt_r <= rst_cnt_r + TMR_W'(1);
      end
   end

   // =========================================================
   // standby wake/fault latch
   // latch rx low on wake, fault or power-up
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rxd_latch_r <= 1'b0;
      end else if (mode_r == SMF_NORMAL) begin
         rxd_latch_r <= 1'b0;                  // released in normal
      end else if (rxd_set_w) begin
         rxd_latch_r <= 1'b1;                  // wake, fault, power-up, timeout
      end
   end

   // =========================================================
   // registered outputs
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bus_tx_en          <= 1'b0;
         bus_rx_en          <= 1'b0;
         bus_tx_out         <= 1'b1;
         rx_data_out        <= RXD_RST;
         reg_en             <= 1'b0;
         supply_inhibit_out <= 1'b0;
         reset_n_io_out     <= 1'b0;
         reset_n_io_oe      <= 1'b1;
         overtemperature_fault <= 1'b0;
         mode_out           <= 3'h0;
      end else begin
         bus_tx_en   <= (mode_nxt == SMF_NORMAL);
         bus_rx_en   <= (mode_nxt == SMF_NORMAL);
         bus_tx_out  <= (mode_nxt == SMF_NORMAL) ? txd_s : 1'b1;
         rx_data_out <= (mode_nxt == SMF_NORMAL) ? brx_s : !(rxd_latch_r || rxd_set_w);
         reg_en      <= (mode_nxt == SMF_NORMAL) || (mode_nxt == SMF_STANDBY) ||
                        (mode_nxt == SMF_RESET);
         supply_inhibit_out <= (mode_nxt == SMF_NORMAL) || (mode_nxt == SMF_STANDBY) ||
                               (mode_nxt == SMF_RESET);
         reset_n_io_out <= 1'b0;
         reset_n_io_oe  <= (mode_nxt == SMF_RESET) || (mode_nxt == SMF_FAILSAFE) ||
                           (mode_nxt == SMF_OFF);
         overtemperature_fault <= tsd_r || otr_s;
         mode_out    <= 3'(mode_nxt);
      end
   end

   // =========================================================
   // assertions
   sequence s_ot;
      otr_s;
   endsequence
   property p_ot_failsafe;
      @(posedge mclk) disable iff (!rst_b)
         s_ot ##1 1'b1 |-> (mode_r == SMF_FAILSAFE) ##1 (!bus_tx_en && !bus_rx_en);
   endproperty
   a_ot_failsafe: assert property (p_ot_failsafe) else $error("ot not failsafe");

   property p_tsd_hold;
      @(posedge mclk) disable iff (!rst_b)
         (tsd_r && !otf_s) |=> tsd_r;
   endproperty
   a_tsd_hold: assert property (p_tsd_hold) else $error("thermal flag dropped early");

   property p_tsd_set;
      @(posedge mclk) disable iff (!rst_b)
         $rose(otr_s) |=> tsd_r;
   endproperty
   a_tsd_set: assert property (p_tsd_set) else $error("thermal flag not set");

   property p_uvreg_reset;
      @(posedge mclk) disable iff (!rst_b)
         (uvreg_s && !otr_s && !ovreg_s && mode_r == SMF_NORMAL) |=> mode_r == SMF_RESET;
   endproperty
   a_uvreg_reset: assert property (p_uvreg_reset) else $error("uv not reset");

   property p_reset_stay;
      @(posedge mclk) disable iff (!rst_b)
         (mode_r == SMF_RESET && uvreg_s && !otr_s && !ovreg_s) |=> mode_r == SMF_RESET;
   endproperty
   a_reset_stay: assert property (p_reset_stay) else $error("left reset during uv");

   property p_ov_failsafe;
      @(posedge mclk) disable iff (!rst_b)
         (ovreg_s && mode_r != SMF_OFF) |=> mode_r == SMF_FAILSAFE;
   endproperty
   a_ov_failsafe: assert property (p_ov_failsafe) else $error("ov not failsafe");

   property p_timer_normal;
      @(posedge mclk) disable iff (!rst_b)
         (mode_r != SMF_STANDBY) |=> inact_r == '0;
   endproperty
   a_timer_normal: assert property (p_timer_normal) else $error("timer ran outside standby");

   property p_timeout_sleep;
      @(posedge mclk) disable iff (!rst_b)
         (timeout_w && !otr_s && !ovreg_s && !uvreg_s) |=>
            (mode_r == SMF_SLEEP) && !supply_inhibit_out && !reg_en;
   endproperty
   a_timeout_sleep: assert property (p_timeout_sleep) else $error("timeout not sleep");

   property p_failsafe_wake;
      @(posedge mclk) disable iff (!rst_b)
         (mode_r == SMF_FAILSAFE && fault_w) |=> mode_r == SMF_FAILSAFE;
   endproperty
   a_failsafe_wake: assert property (p_failsafe_wake) else $error("woke with fault");

   property p_inh_mode;
      @(posedge mclk) disable iff (!rst_b)
         (mode_r == SMF_SLEEP || mode_r == SMF_FAILSAFE) |-> !supply_inhibit_out && !reg_en;
   endproperty
   a_inh_mode: assert property (p_inh_mode) else $error("inhibit on in sleep");
endmodule : smf_ctrl

/* File: hdl/smf_pkg.sv */
// mode and fault controller package: modes, timing constants
// assumes a 10 MHz mclk; all counts derived from times in us
package smf_pkg;
   // =========================================================
   // modes
   typedef enum logic [2:0] {
      SMF_OFF, SMF_NORMAL, SMF_STANDBY, SMF_SLEEP, SMF_RESET, SMF_FAILSAFE
   } smf_mode_e;

   // =========================================================
   // timing
   localparam int unsigned CLK_MHZ            = 10;    // mclk rate
   localparam int unsigned SLEEP_HOLD_US      = 50;    // sleep hold time
   localparam int unsigned INACTIVE_US        = 1000;  // inactivity timeout
   localparam int unsigned COLD_RST_US        = 200;   // cold reset hold
   localparam int unsigned SLEEP_HOLD_CYC     = SLEEP_HOLD_US * CLK_MHZ;
   localparam int unsigned INACTIVE_CYC       = INACTIVE_US * CLK_MHZ;
   localparam int unsigned COLD_RST_CYC       = COLD_RST_US * CLK_MHZ;
   localparam int unsigned TMR_W              = 24;    // timer width
   // reset values
   localparam logic        RXD_RST            = 1'b1;  // rx line idle high
endpackage : smf_pkg

/* File: hdl/smf_sync.sv */
// two-flop synchroniser bank for asynchronous input flags
// assumes inputs may change at any time relative to mclk
`timescale 1ns/1ps
module smf_sync #(
   parameter int unsigned  W       = 1,
   parameter logic [W-1:0] RST_VAL = '0   // idle level of each input
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   logic [W-1:0] meta_r;   // first stage, read only by second stage

   // refuse an empty bank
   if (W < 1) begin : g_chk_w
      $error("smf_sync: width must be at least one");
   end

   // =========================================================
   // two stages; both reset to the idle pattern so no false edge follows reset
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_r   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_r   <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule : smf_sync

/* File: tb/smf_host.sv */
// host model: drives the sleep input and transmit data of the controller
// assumes the bench gives it plain requests, sampled on mclk
`timescale 1ns/1ps
module smf_host (
   input  wire logic mclk,
   input  wire logic rst_b,
   input  wire logic go_low,          // bench asks for low power
   input  wire logic tx_bit,          // next transmit level
   output logic      sleep_control_n, // host mode pin
   output logic      tx_data_in       // host transmit pin
);
   // ==========================================================
   // pin drivers
   // hold sleep pin low
   // level held for as long as the bench asks, never pulsed
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sleep_control_n <= 1'b1;
         tx_data_in      <= 1'b1;      // recessive
      end else begin
         sleep_control_n <= !go_low;
         tx_data_in      <= tx_bit;
      end
   end
endmodule : smf_host

/* File: tb/tb.sv */
// self-checking bench for the mode and fault controller
// assumes short timer parameters; host model drives the host pins
`timescale 1ns/1ps
module tb;
   import smf_pkg::*;
   // ==========================================================
   // settings and signals
   localparam int INACT = 16;         // shortened inactivity count
   localparam int COLD  = 12;         // shortened cold reset count
   localparam int SLP   = 8;          // shortened sleep hold count
   logic       mclk, rst_b, go_low, tx_bit, bus_rx_in;
   logic       ot_rise, ot_fall, uv_io, uv_reg, ov_reg, wake_evt;
   logic       sleep_control_n, tx_data_in, reset_n_io_in;
   logic       reset_n_io_out, reset_n_io_oe, bus_tx_en, bus_rx_en;
   logic       bus_tx_out, rx_data_out, reg_en, supply_inhibit_out;
   logic       overtemperature_fault;
   logic [2:0] mode_out;
   int         errors, n_compared, cyc;

   // open-drain reset line with pull-up
   assign reset_n_io_in = reset_n_io_oe ? reset_n_io_out : 1'b1;

   smf_host host_u (.mclk(mclk), .rst_b(rst_b), .go_low(go_low), .tx_bit(tx_bit),
      .sleep_control_n(sleep_control_n), .tx_data_in(tx_data_in));

   smf_ctrl #(.INACTIVE_CNT(INACT), .COLD_RST_CNT(COLD), .SLEEP_CNT(SLP)) dut_u (
      .mclk(mclk), .rst_b(rst_b), .sleep_control_n(sleep_control_n),
      .tx_data_in(tx_data_in), .bus_rx_in(bus_rx_in), .ot_rise(ot_rise),
      .ot_fall(ot_fall), .uv_io(uv_io), .uv_reg(uv_reg), .ov_reg(ov_reg),
      .wake_evt(wake_evt), .reset_n_io_in(reset_n_io_in),
      .reset_n_io_out(reset_n_io_out), .reset_n_io_oe(reset_n_io_oe),
      .bus_tx_en(bus_tx_en), .bus_rx_en(bus_rx_en), .bus_tx_out(bus_tx_out),
      .rx_data_out(rx_data_out), .reg_en(reg_en),
      .supply_inhibit_out(supply_inhibit_out),
      .overtemperature_fault(overtemperature_fault), .mode_out(mode_out));

   // ==========================================================
   // clock and hang guard
   always #50 mclk = ~mclk;           // 10 MHz
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin          // run needs well under 1000
         errors++;
         print_verdict();
      end
   end

   // ==========================================================
   // helpers
   task automatic chk(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("Error t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic chk_mode(input logic [2:0] exp);
      n_compared++;
      if (mode_out !== exp) begin
         errors++;
         $display("Error t=%0t got %h exp %h", $time, mode_out, exp);
      end
   endtask : chk_mode

   // wait for a mode, bounded; returns cycles taken
   task automatic wait_mode(input logic [2:0] m, input int lim, output int n);
      n = 0;
      while (mode_out !== m && n < lim) begin
         @(posedge mclk);
         #1;
         n++;
      end
      chk_mode(m);
   endtask : wait_mode

   task automatic wake_pulse;
      @(posedge mclk) wake_evt <= 1'b1;
      repeat (2) @(posedge mclk);
      wake_evt <= 1'b0;
   endtask : wake_pulse

   // outputs common to a mode: regulators, inhibit, transceiver
   task automatic chk_outs(input logic on, input logic trx);
      chk(reg_en, on);
      chk(supply_inhibit_out, on);
      chk(bus_tx_en, trx);
      chk(bus_rx_en, trx);
   endtask : chk_outs

   // ==========================================================
   // scenarios
   // cold reset from power-up, then normal
   task automatic t_cold;
      int n;
      wait_mode(SMF_RESET, 6, n);
      repeat (8) begin
         @(posedge mclk);
         #1;
         chk(reset_n_io_oe, 1'b1);
      end
      wait_mode(SMF_NORMAL, COLD + 8, n);
      chk_outs(1'b1, 1'b1);
      chk(reset_n_io_out, 1'b0);
      chk(reset_n_io_oe, 1'b0);
   endtask : t_cold

   // transmit and receive paths in normal mode
   task automatic t_data;
      for (int b = 0; b < 2; b++) begin
         @(posedge mclk);
         tx_bit    <= b[0];
         bus_rx_in <= !b[0];
         repeat (5) @(posedge mclk);
         #1;
         chk(bus_tx_out, b[0]);
         chk(rx_data_out, !b[0]);
      end
   endtask : t_data

   // normal to standby, then sleep once the hold time has passed
   task automatic t_hold;
      int n;
      @(posedge mclk) go_low <= 1'b1;
      wait_mode(SMF_STANDBY, 8, n);
      chk_outs(1'b1, 1'b0);
      wait_mode(SMF_SLEEP, SLP + 6, n);
      chk((n >= SLP - 3) && (n <= SLP + 2), 1'b1);
      chk(rx_data_out, 1'b1);
      chk_outs(1'b0, 1'b0);
   endtask : t_hold

   // wake from sleep, host stays silent, inactivity expiry, sleep again
   task automatic t_timeout;
      int n;
      wake_pulse();
      wait_mode(SMF_STANDBY, 8, n);
      chk(rx_data_out, 1'b0);
      wait_mode(SMF_SLEEP, INACT + 6, n);
      chk((n >= INACT - 3) && (n <= INACT + 2), 1'b1);
      chk(rx_data_out, 1'b0);
      chk_outs(1'b0, 1'b0);
   endtask : t_timeout

   // wake from sleep, rx latched low, host returns to normal
   task automatic t_wake;
      int n;
      wake_pulse();
      wait_mode(SMF_STANDBY, 8, n);
      chk(rx_data_out, 1'b0);
      chk_outs(1'b1, 1'b0);
      @(posedge mclk) go_low <= 1'b0;
      wait_mode(SMF_NORMAL, 8, n);
      repeat (3) @(posedge mclk);
      #1;
      chk(rx_data_out, bus_rx_in);
   endtask : t_wake

   // supply undervoltages
   task automatic t_uv;
      int n;
      @(posedge mclk) uv_reg <= 1'b1;
      wait_mode(SMF_RESET, 8, n);
      repeat (30) @(posedge mclk);
      #1;
      chk_mode(SMF_RESET);
      chk(reset_n_io_oe, 1'b1);
      @(posedge mclk) uv_reg <= 1'b0;
      wait_mode(SMF_NORMAL, COLD + 8, n);
      chk(n >= COLD - 2, 1'b1);
      @(posedge mclk) uv_io <= 1'b1;
      wait_mode(SMF_SLEEP, 8, n);
      chk_outs(1'b0, 1'b0);
      @(posedge mclk) uv_io <= 1'b0;
      @(posedge mclk) go_low <= 1'b1;
      t_wake();
   endtask : t_uv

   // fault into fail-safe, wakes refused until the fault clears
   task automatic t_fault(input bit thermal);
      int n;
      @(posedge mclk);
      if (thermal) ot_rise <= 1'b1;
      else ov_reg <= 1'b1;
      wait_mode(SMF_FAILSAFE, 8, n);
      chk_outs(1'b0, 1'b0);
      chk(overtemperature_fault, thermal);
      @(posedge mclk) ot_rise <= 1'b0;
      wake_pulse();
      repeat (6) @(posedge mclk);
      #1;
      chk_mode(thermal ? SMF_FAILSAFE : SMF_FAILSAFE);
      chk(overtemperature_fault, thermal);
      @(posedge mclk);
      ot_fall <= 1'b1;
      ov_reg  <= 1'b0;
      repeat (5) @(posedge mclk);
      #1;
      chk(overtemperature_fault, 1'b0);
      @(posedge mclk) ot_fall <= 1'b0;
      wake_pulse();
      wait_mode(SMF_RESET, 8, n);
      chk(reset_n_io_oe, 1'b1);
      wait_mode(SMF_NORMAL, COLD + 8, n);
   endtask : t_fault

   // ==========================================================
   // verdict
   task automatic print_verdict;
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // ==========================================================
   // main sequence
   initial begin
      mclk = 1'b0; rst_b = 1'b0; go_low = 1'b0; tx_bit = 1'b1; bus_rx_in = 1'b1;
      ot_rise = 1'b0; ot_fall = 1'b0; uv_io = 1'b0; uv_reg = 1'b0;
      ov_reg = 1'b0; wake_evt = 1'b0; errors = 0; n_compared = 0; cyc = 0;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      t_cold();
      t_data();
      t_hold();
      t_timeout();
      t_wake();
      t_hold();
      t_timeout();
      t_wake();
      t_uv();
      t_fault(1'b1);
      t_fault(1'b1);
      t_fault(1'b0);
      print_verdict();
   end
endmodule : tb
